// >>> design/fslo_pkg.sv
// Shared constants and types for the flash suspend, lock and OTP host
package fslo_pkg;

  // Flash pin widths
  localparam int ADDR_W = 24; // Flash address lines
  localparam int DATA_W = 16; // Flash data lines

  // Clock rate and pin timing, times in ns
  localparam int CLK_MHZ = 250;
  localparam int T_WE_NS = 100; // Write strobe low time
  localparam int T_ACC_NS = 150; // Read strobe to data valid
  localparam int T_RECOV_NS = 40; // Strobes high between cycles
  localparam logic [7:0] WE_CYC = 8'((T_WE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RD_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RECOV_CYC =
    8'((T_RECOV_NS * CLK_MHZ + 999) / 1000);

  // Status byte bit positions
  localparam int SR_READY = 7; // Ready flag
  localparam int SR_ESUSP = 6; // Erase suspended flag
  localparam int SR_EERR = 5; // Erase error flag
  localparam int SR_PERR = 4; // Program error flag
  localparam int SR_VERR = 3; // Voltage error flag
  localparam int SR_PSUSP = 2; // Program suspended flag
  localparam int SR_LERR = 1; // Lock error flag
  localparam logic [7:0] SR_ERR_MASK = 8'h3a; // Bits 5, 4, 3 and 1

  // Documented command codes
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;

  // OTP register map, indices as the address low bits
  localparam int OTP_SEL_BIT = 8; // A8 set, all lines above zero
  localparam logic [4:0] OTP_WORD_LAST = 5'h08; // Lock word plus 8 words
  localparam logic [4:0] OTP_WORD_USER = 5'h05; // First user word
  localparam logic [4:0] OTP_BYTE_LAST = 5'h11; // Two lock plus 16 bytes
  localparam logic [4:0] OTP_BYTE_USER = 5'h0a; // First user byte
  localparam logic [4:0] OTP_LOCK_IDX = 5'h00; // Lock word or low lock byte
  localparam logic [15:0] OTP_LOCK_VAL = 16'hfffd; // Zeroes bit 1 only

  // Step kinds of a command sequence
  localparam logic [1:0] K_WR = 2'h0;
  localparam logic [1:0] K_RD = 2'h1;
  localparam logic [1:0] K_POLL = 2'h2;
  localparam logic [1:0] K_END = 2'h3;

  // User operations
  typedef enum logic [3:0] {
    OP_ERS_SUSP = 4'h0,
    OP_ERS_RES = 4'h1,
    OP_PRG = 4'h2,
    OP_PRG_SUSP = 4'h3,
    OP_PRG_RES = 4'h4,
    OP_SET_LOCK = 4'h5,
    OP_CLR_LOCK = 4'h6,
    OP_OTP_RD = 4'h7,
    OP_OTP_PRG = 4'h8,
    OP_OTP_LOCK = 4'h9,
    OP_RD_STAT = 4'ha,
    OP_CLR_STAT = 4'hb
  } fslo_op_t;

  // One step of a sequence
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] data;
  } fslo_step_t;

  // One flash bus cycle
  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fslo_bus_req_t;

endpackage

// >>> design/fslo_bus.sv
// Single flash bus cycle engine: chip enable, strobes and data pins
`timescale 1ns/1ps
module fslo_bus (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Cycle request and answer
  input wire logic req_valid,
  input wire fslo_pkg::fslo_bus_req_t req,
  input wire logic byte_mode,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);

  // Cycle phases
  typedef enum logic [1:0] {
    B_IDLE = 2'h0,
    B_SETUP = 2'h1,
    B_PULSE = 2'h2,
    B_RECOV = 2'h3
  } fslo_bphase_t;

  fslo_bphase_t state_q; // Current phase
  logic [7:0] cnt_q; // Phase cycle counter
  logic rd_q; // Cycle is a read
  logic [15:0] dq_s1_q; // Data pin synchroniser stages
  logic [15:0] dq_s2_q;
  logic [15:0] dq_s3_q;
  logic rsp_valid_q; // Answer pulse
  logic [15:0] rsp_data_q; // Captured read data
  logic ce_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic [23:0] addr_q;
  logic [15:0] dq_o_q;
  logic [15:0] dq_oe_q;

  // Named decode terms
  wire dq_stable = (dq_s2_q == dq_s3_q);
  wire [15:0] lane_mask = byte_mode ? 16'h00ff : 16'hffff;
  wire pulse_end = (cnt_q <= 8'h01) && (!rd_q || dq_stable);

  assign req_ready = (state_q == B_IDLE);
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_we_n = we_n_q;
  assign flash_addr = addr_q;
  assign flash_dq_o = dq_o_q;
  assign flash_dq_oe = dq_oe_q;

  // Three stage synchroniser on the data pins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      dq_s3_q <= 16'h0000;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // Cycle sequencer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= B_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 24'h000000;
      dq_o_q <= 16'h0000;
      dq_oe_q <= 16'h0000;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        B_IDLE: begin
          // Address and chip enable settle before the strobe
          if (req_valid) begin
            rd_q <= req.rd;
            addr_q <= req.addr;
            dq_o_q <= req.wdata & lane_mask;
            dq_oe_q <= req.rd ? 16'h0000 : lane_mask;
            ce_n_q <= 1'b0;
            state_q <= B_SETUP;
          end
        end
        B_SETUP: begin
          // Reads add the synchroniser delay to the access time
          cnt_q <= rd_q ? 8'(fslo_pkg::RD_CYC + 8'h03) : fslo_pkg::WE_CYC;
          we_n_q <= rd_q;
          oe_n_q <= !rd_q;
          state_q <= B_PULSE;
        end
        B_PULSE: begin
          // Hold the strobe until time is up and read data is steady
          if (!pulse_end) begin
            if (cnt_q > 8'h01) begin
              cnt_q <= cnt_q - 8'h01;
            end
          end else begin
            if (rd_q) begin
              rsp_data_q <= dq_s3_q & lane_mask;
            end
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            cnt_q <= fslo_pkg::RECOV_CYC;
            state_q <= B_RECOV;
          end
        end
        B_RECOV: begin
          // Data held past the rising write strobe, then released
          ce_n_q <= 1'b1;
          dq_oe_q <= 16'h0000;
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            rsp_valid_q <= 1'b1;
            state_q <= B_IDLE;
          end
        end
        default: begin
          state_q <= B_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> design/fslo_host.sv
// Host sequencer for erase/program suspend, block locks and OTP access
`timescale 1ns/1ps
// Summary of operation
// - Erase resume refused until nested program ends
// - First resume program, second erase; two levels
// - Lock set: setup, confirm, never while erase suspended or nested program started
// - Failed clear-lock is repeated once
// - Check errors after lock ops, clear status
// - OTP read via identify mode, then array
// - OTP program: setup then one data write
// - Lock OTP user half writing lock value
// - OTP addresses zero above A8; A0 bytes
module fslo_host #(
  parameter logic [7:0] CMD_SUSPEND = 8'hb0,
  parameter logic [7:0] CMD_RESUME = 8'hd0,
  parameter logic [7:0] CMD_PROGRAM = 8'h40,
  parameter logic [7:0] CMD_LOCK_SETUP = 8'h60,
  parameter logic [7:0] CMD_LOCK_SET = 8'h01,
  parameter logic [7:0] CMD_LOCK_CLEAR = 8'hd0,
  parameter logic [7:0] CMD_READ_STATUS = 8'h70,
  parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // User command port
  input wire logic cmd_valid,
  input wire fslo_pkg::fslo_op_t cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic byte_mode,
  output logic cmd_ready,
  output logic cmd_refused,
  output logic done,
  output logic done_err,
  output logic [15:0] rsp_data,
  output logic [7:0] rsp_status,
  // Tracked device state
  output logic erase_suspended,
  output logic program_running,
  output logic program_suspended,
  output logic lock_bits_unknown,
  output logic ready_level,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  input wire logic flash_sts
);

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_STEP = 3'h1,
    S_BUS = 3'h2,
    S_WAIT_STS = 3'h3,
    S_CLRST = 3'h4,
    S_DONE = 3'h5
  } fslo_state_t;

  fslo_state_t state_q; // Sequencer state
  fslo_pkg::fslo_op_t op_q; // Operation in progress
  logic [1:0] idx_q; // Step index
  logic [23:0] addr_q; // Address for every cycle
  logic [15:0] data_q; // User data word
  logic [7:0] status_q; // Last status byte
  logic [15:0] rdata_q; // Last read word
  logic poll_q; // Bus cycle is a status poll
  logic clr_q; // Bus cycle is a clear status
  logic restart_q; // Rerun sequence after clear
  logic retry_q; // Clear-lock already repeated
  logic err_q; // Operation ended in error
  logic done_q;
  logic refused_q;
  logic es_q; // Erase suspended
  logic pr_q; // Nested program started
  logic ps_q; // Nested program suspended
  logic unknown_q; // Lock bits undetermined
  logic sts_s1_q; // Ready pin synchroniser stages
  logic sts_s2_q;
  logic sts_s3_q;
  logic bus_ready; // Engine idle
  logic bus_rsp; // Engine finished a cycle
  logic [15:0] bus_rdata; // Engine read data
  fslo_pkg::fslo_bus_req_t bus_req; // Cycle to run

  // Step constructor
  function automatic fslo_pkg::fslo_step_t mk(input logic [1:0] k,
                                              input logic [15:0] d);
    return fslo_pkg::fslo_step_t'({k, d});
  endfunction

  // Command write step
  function automatic fslo_pkg::fslo_step_t wc(input logic [7:0] c);
    return mk(fslo_pkg::K_WR, {8'h00, c});
  endfunction

  // OTP address: A8 set, lines above zero, A0 only in byte mode
  function automatic logic [23:0] otp_addr(input logic [4:0] i,
                                           input logic bm);
    logic [23:0] a;
    a = 24'h000000;
    a[fslo_pkg::OTP_SEL_BIT] = 1'b1;
    if (bm) begin
      a[4:0] = i;
    end else begin
      a[4:1] = i[3:0];
    end
    return a;
  endfunction

  // Sequence table, four steps per operation
  function automatic fslo_pkg::fslo_step_t step_of(
      input fslo_pkg::fslo_op_t op, input logic [1:0] i,
      input logic [15:0] d);
    fslo_pkg::fslo_step_t s [4];
    fslo_pkg::fslo_step_t p;
    fslo_pkg::fslo_step_t e;
    p = mk(fslo_pkg::K_POLL, 16'h0000);
    e = mk(fslo_pkg::K_END, 16'h0000);
    s = '{e, e, e, e};
    case (op)
      fslo_pkg::OP_ERS_SUSP: s = '{wc(CMD_SUSPEND), p, e, e};
      fslo_pkg::OP_ERS_RES: s = '{wc(CMD_RESUME), e, e, e};
      fslo_pkg::OP_PRG: s = '{wc(CMD_PROGRAM), mk(fslo_pkg::K_WR, d), e, e};
      fslo_pkg::OP_PRG_SUSP: s = '{wc(CMD_SUSPEND), p, e, e};
      fslo_pkg::OP_PRG_RES: s = '{wc(CMD_RESUME), e, e, e};
      fslo_pkg::OP_SET_LOCK:
        s = '{wc(CMD_LOCK_SETUP), wc(CMD_LOCK_SET), p, e};
      fslo_pkg::OP_CLR_LOCK:
        s = '{wc(CMD_LOCK_SETUP), wc(CMD_LOCK_CLEAR), p, e};
      fslo_pkg::OP_OTP_RD:
        s = '{wc(fslo_pkg::CMD_READ_ID), mk(fslo_pkg::K_RD, 16'h0000),
              wc(fslo_pkg::CMD_READ_ARRAY), e};
      fslo_pkg::OP_OTP_PRG:
        s = '{wc(fslo_pkg::CMD_OTP_SETUP), mk(fslo_pkg::K_WR, d),
              p, e};
      fslo_pkg::OP_OTP_LOCK:
        s = '{wc(fslo_pkg::CMD_OTP_SETUP),
              mk(fslo_pkg::K_WR, fslo_pkg::OTP_LOCK_VAL), p, e};
      fslo_pkg::OP_RD_STAT:
        s = '{wc(CMD_READ_STATUS), mk(fslo_pkg::K_RD, 16'h0000), e, e};
      fslo_pkg::OP_CLR_STAT: s = '{wc(CMD_CLEAR_STATUS), e, e, e};
      default: s = '{e, e, e, e};
    endcase
    return s[i];
  endfunction

  // Operations that end by polling status
  function automatic logic polled(input fslo_pkg::fslo_op_t op);
    return (op == fslo_pkg::OP_ERS_SUSP) || (op == fslo_pkg::OP_PRG_SUSP) ||
           (op == fslo_pkg::OP_SET_LOCK) || (op == fslo_pkg::OP_CLR_LOCK) ||
           (op == fslo_pkg::OP_OTP_PRG) || (op == fslo_pkg::OP_OTP_LOCK);
  endfunction

  // Acceptance decode
  wire [4:0] cmd_idx = cmd_addr[4:0];
  wire [4:0] otp_last = byte_mode ? fslo_pkg::OTP_BYTE_LAST :
                                    fslo_pkg::OTP_WORD_LAST;
  wire [4:0] otp_user = byte_mode ? fslo_pkg::OTP_BYTE_USER :
                                    fslo_pkg::OTP_WORD_USER;
  wire quiet = !es_q && !pr_q;
  wire otp_in_map = (cmd_idx <= otp_last);
  wire otp_user_idx = (cmd_idx >= otp_user) && otp_in_map;
  logic legal;
  always_comb begin
    case (cmd_op)
      fslo_pkg::OP_ERS_SUSP: legal = !es_q;
      fslo_pkg::OP_ERS_RES: legal = es_q && !pr_q && !ps_q;
      fslo_pkg::OP_PRG: legal = !pr_q && !ps_q;
      fslo_pkg::OP_PRG_SUSP: legal = pr_q && !ps_q;
      fslo_pkg::OP_PRG_RES: legal = ps_q;
      fslo_pkg::OP_SET_LOCK: legal = quiet;
      fslo_pkg::OP_CLR_LOCK: legal = quiet;
      fslo_pkg::OP_OTP_RD: legal = quiet && otp_in_map;
      fslo_pkg::OP_OTP_PRG: legal = quiet && otp_user_idx;
      fslo_pkg::OP_OTP_LOCK: legal = quiet;
      fslo_pkg::OP_RD_STAT: legal = 1'b1;
      fslo_pkg::OP_CLR_STAT: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // Address per operation; resumes and suspends go to address zero
  wire is_otp = (cmd_op == fslo_pkg::OP_OTP_RD) ||
                (cmd_op == fslo_pkg::OP_OTP_PRG);
  wire is_user_addr = (cmd_op == fslo_pkg::OP_PRG) ||
                      (cmd_op == fslo_pkg::OP_SET_LOCK);
  wire [23:0] cmd_phys =
    is_otp ? otp_addr(cmd_idx, byte_mode) :
    (cmd_op == fslo_pkg::OP_OTP_LOCK) ?
      otp_addr(fslo_pkg::OTP_LOCK_IDX, byte_mode) :
    is_user_addr ? cmd_addr : 24'h000000;

  // Current step and bus request decode
  wire fslo_pkg::fslo_step_t cur = step_of(op_q, idx_q, data_q);
  wire sts_high = sts_s2_q && sts_s3_q;
  wire step_bus = (state_q == S_STEP) &&
                  ((cur.kind == fslo_pkg::K_WR) ||
                   (cur.kind == fslo_pkg::K_RD));
  wire poll_go = (state_q == S_WAIT_STS) && sts_high;
  wire bus_valid = step_bus || poll_go || (state_q == S_CLRST);
  wire bus_take = bus_valid && bus_ready;
  wire has_err = polled(op_q) && |(status_q & fslo_pkg::SR_ERR_MASK);
  wire [1:0] idx_next = 2'(idx_q + 2'h1);

  assign bus_req.rd = poll_go || (cur.kind == fslo_pkg::K_RD);
  assign bus_req.addr = addr_q;
  assign bus_req.wdata = (state_q == S_CLRST) ? {8'h00, CMD_CLEAR_STATUS} :
                                                cur.data;
  assign cmd_ready = (state_q == S_IDLE);
  assign cmd_refused = refused_q;
  assign done = done_q;
  assign done_err = err_q;
  assign rsp_data = rdata_q;
  assign rsp_status = status_q;
  assign erase_suspended = es_q;
  assign program_running = pr_q;
  assign program_suspended = ps_q;
  assign lock_bits_unknown = unknown_q;
  assign ready_level = sts_high;

  // Three stage synchroniser on the ready status pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sts_s1_q <= 1'b0;
      sts_s2_q <= 1'b0;
      sts_s3_q <= 1'b0;
    end else begin
      sts_s1_q <= flash_sts;
      sts_s2_q <= sts_s1_q;
      sts_s3_q <= sts_s2_q;
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      op_q <= fslo_pkg::OP_RD_STAT;
      idx_q <= 2'h0;
      addr_q <= 24'h000000;
      data_q <= 16'h0000;
      status_q <= 8'h00;
      rdata_q <= 16'h0000;
      poll_q <= 1'b0;
      clr_q <= 1'b0;
      restart_q <= 1'b0;
      retry_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      es_q <= 1'b0;
      pr_q <= 1'b0;
      ps_q <= 1'b0;
      unknown_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Take or refuse one user command
          if (cmd_valid && legal) begin
            op_q <= cmd_op;
            addr_q <= cmd_phys;
            data_q <= cmd_data;
            idx_q <= 2'h0;
            err_q <= 1'b0;
            retry_q <= 1'b0;
            state_q <= S_STEP;
          end else if (cmd_valid) begin
            refused_q <= 1'b1;
          end
        end
        S_STEP: begin
          // Launch a cycle, start polling, or finish
          if (cur.kind == fslo_pkg::K_POLL) begin
            state_q <= S_WAIT_STS;
          end else if (cur.kind == fslo_pkg::K_END) begin
            if (has_err) begin
              // Clear the errors before handing back
              restart_q <= (op_q == fslo_pkg::OP_CLR_LOCK) && !retry_q;
              retry_q <= 1'b1;
              err_q <= 1'b1;
              state_q <= S_CLRST;
            end else begin
              state_q <= S_DONE;
            end
          end else if (bus_take) begin
            poll_q <= 1'b0;
            state_q <= S_BUS;
          end
        end
        S_WAIT_STS: begin
          // Poll only while the ready pin says ready or suspended
          if (bus_take) begin
            poll_q <= 1'b1;
            state_q <= S_BUS;
          end
        end
        S_CLRST: begin
          if (bus_take) begin
            clr_q <= 1'b1;
            state_q <= S_BUS;
          end
        end
        S_BUS: begin
          // Act on the finished cycle
          if (bus_rsp) begin
            if (clr_q) begin
              clr_q <= 1'b0;
              restart_q <= 1'b0;
              if (restart_q) begin
                err_q <= 1'b0;
                idx_q <= 2'h0;
                state_q <= S_STEP;
              end else begin
                state_q <= S_DONE;
              end
            end else if (poll_q) begin
              status_q <= bus_rdata[7:0];
              if (bus_rdata[fslo_pkg::SR_READY]) begin
                idx_q <= idx_next;
                state_q <= S_STEP;
              end else begin
                state_q <= S_WAIT_STS;
              end
            end else begin
              if (cur.kind == fslo_pkg::K_RD) begin
                rdata_q <= bus_rdata;
                if (op_q == fslo_pkg::OP_RD_STAT) begin
                  status_q <= bus_rdata[7:0];
                end
              end
              idx_q <= idx_next;
              state_q <= S_STEP;
            end
          end
        end
        S_DONE: begin
          // Track the suspend nesting from what the device reported
          done_q <= 1'b1;
          state_q <= S_IDLE;
          case (op_q)
            fslo_pkg::OP_ERS_SUSP: es_q <= status_q[fslo_pkg::SR_ESUSP];
            fslo_pkg::OP_ERS_RES: es_q <= 1'b0;
            fslo_pkg::OP_PRG: pr_q <= 1'b1;
            fslo_pkg::OP_PRG_SUSP: begin
              ps_q <= status_q[fslo_pkg::SR_PSUSP];
              pr_q <= status_q[fslo_pkg::SR_PSUSP];
            end
            fslo_pkg::OP_PRG_RES: ps_q <= 1'b0;
            fslo_pkg::OP_CLR_LOCK: unknown_q <= err_q;
            fslo_pkg::OP_RD_STAT: begin
              // Ready with no program suspend: nested program finished
              if (pr_q && !ps_q && status_q[fslo_pkg::SR_READY]) begin
                pr_q <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Flash cycle engine
  fslo_bus u_bus (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .req_valid(bus_valid),
    .req(bus_req),
    .byte_mode(byte_mode),
    .req_ready(bus_ready),
    .rsp_valid(bus_rsp),
    .rsp_data(bus_rdata),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

endmodule

// >>> tb/fslo_host_asserts.sv
// Port assertions for the suspend, lock and OTP host
`timescale 1ns/1ps
module fslo_host_asserts (
  // Clock, reset and user port
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire fslo_pkg::fslo_op_t cmd_op,
  input wire logic cmd_ready,
  input wire logic cmd_refused,
  input wire logic done,
  input wire logic [7:0] rsp_status,
  input wire logic erase_suspended,
  input wire logic program_suspended,
  input wire logic ready_level,
  // Flash pins
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [15:0] flash_dq_oe,
  input wire logic flash_sts
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire tk = cmd_valid && cmd_ready; // Request taken
  property p_ref; cmd_refused |-> $past(tk); endproperty
  a_ref: assert property (p_ref) else $error("stray refusal");
  property p_eres; tk && cmd_op == fslo_pkg::OP_ERS_RES &&
    program_suspended |=> cmd_refused; endproperty
  a_eres: assert property (p_eres) else $error("early resume");
  property p_esus; tk && cmd_op == fslo_pkg::OP_ERS_SUSP &&
    erase_suspended |=> cmd_refused; endproperty
  a_esus: assert property (p_esus) else $error("third level");
  property p_rdy; done |=> cmd_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("not idle");
  property p_we; $fell(flash_we_n) |->
    !flash_ce_n ##24 !flash_we_n ##1 flash_we_n; endproperty
  a_we: assert property (p_we) else $error("write strobe");
  property p_dq; !flash_oe_n |-> flash_dq_oe == 16'h0000; endproperty
  a_dq: assert property (p_dq) else $error("read contention");
  property p_sts; ready_level |->
    $past(flash_sts, 2) && $past(flash_sts, 3); endproperty
  a_sts: assert property (p_sts) else $error("ready sync");
  property p_es; $rose(erase_suspended) |->
    done && rsp_status[7:6] == 2'h3; endproperty
  a_es: assert property (p_es) else $error("suspend flag");
endmodule
bind fslo_host fslo_host_asserts fslo_host_asserts_inst (.*);

// >>> tb/fslo_flash_model.sv
// Behavioural flash device with suspend, lock and OTP logic
`timescale 1ns/1ps
module fslo_flash_model (
  // Bus pins
  input wire logic sys_clk,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_i,
  output logic flash_sts,
  // Supply lockout fault
  input wire logic program_enable_voltage_low
);
  logic [15:0] otp [0:8]; // Lock word, factory, user words
  logic [15:0] last = 16'h0; // Last driven read value
  logic [7:0] sr = 8'h0, pc = 8'h0; // Error bits, setup code
  logic es = 1'b0, ps = 1'b0, idm = 1'b0, we_q = 1'b1;
  int ecnt = 400, pcnt = 0, clrs = 0; // Busy times, clear tries
  wire [3:0] ix = flash_addr[4:1];
  wire [7:0] d = flash_dq_o[7:0];
  wire rdy = !((ecnt > 0 && !es) || (pcnt > 0 && !ps));
  assign flash_sts = rdy;
  // Status or OTP word while read, inverted when released
  always_comb
    if (!flash_oe_n && !flash_ce_n)
      flash_dq_i = idm ? otp[ix] : {8'h0, rdy, es, sr[5:3], ps, sr[1], 1'b0};
    else
      flash_dq_i = ~last;
  // Factory words arbitrary, user words blank
  initial begin
    foreach (otp[i]) otp[i] = i > 4 ? 16'hffff : 16'h5a00 + 16'(i);
    otp[0] = 16'hfffe;
  end
  // Busy countdown and command decode at each write strobe end
  always @(posedge sys_clk) begin
    we_q <= flash_we_n;
    if (!flash_oe_n) last <= flash_dq_i;
    if (pcnt > 0 && !ps) pcnt <= pcnt - 1;
    else if (ecnt > 0 && !es) ecnt <= ecnt - 1;
    if (flash_we_n && !we_q && !flash_ce_n) begin
      pc <= 8'h0;
      if (pc == 8'h40) pcnt <= 300;
      else if (pc == 8'hc0) begin
        if (flash_addr[23:5] != 19'h8 || ix > 8)
          sr[4] <= 1'b1;
        else if ((ix < 5 && ix != 0) || (ix > 4 && !otp[0][1]))
          sr <= sr | 8'h12;
        else otp[ix] <= otp[ix] & flash_dq_o;
      end else if (pc == 8'h60) begin
        if (!rdy || es) sr <= sr | 8'h30;
        else if (d == 8'hd0) begin
          clrs <= clrs + 1;
          if (program_enable_voltage_low) sr <= sr | 8'h28;
        end
      end else case (d)
        8'hb0: if (pcnt > 0) ps <= 1'b1; else es <= 1'b1;
        8'hd0: if (ps) ps <= 1'b0;
          else if (pcnt == 0) es <= 1'b0;
        8'h90: idm <= 1'b1;
        8'hff, 8'h70: idm <= 1'b0;
        8'h50: sr <= 8'h0;
        8'h40, 8'h60, 8'hc0: pc <= d;
        default: ;
      endcase
    end
  end
endmodule

// >>> tb/fslo_host_tb_top.sv
// Self-checking bench for the suspend, lock and OTP host
`timescale 1ns/1ps
module fslo_host_tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, program_enable_voltage_low = 1'b0;
  logic byte_mode = 1'b0;
  fslo_pkg::fslo_op_t cmd_op = fslo_pkg::OP_RD_STAT;
  logic [23:0] cmd_addr = 24'h0, flash_addr;
  logic [15:0] cmd_data = 16'h0, rsp_data, flash_dq_o, flash_dq_oe, flash_dq_i;
  logic [7:0] rsp_status;
  logic cmd_ready, cmd_refused, done, done_err, erase_suspended;
  logic program_running, program_suspended, lock_bits_unknown, ready_level;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_sts;
  int mismatches = 0, cmp_count = 0;
  fslo_host fslo_host_inst (.*);
  fslo_flash_model fslo_flash_model_inst (.*);
  // 250 MHz clock
  initial forever #2 sys_clk = ~sys_clk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask
  // One user operation, bounded wait for done or refusal
  task automatic go(input fslo_pkg::fslo_op_t o, input logic [23:0] a = 0,
    input logic [15:0] d = 0, input logic r = 1'b0);
    int n;
    cmd_op = o;
    {cmd_valid, cmd_addr, cmd_data} = {1'b1, a, d};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 4000 && !done && !cmd_refused; n++) @(negedge sys_clk);
    if (n == 4000) begin
      mismatches++;
      final_report();
    end
    chb("refused", r, cmd_refused);
    @(negedge sys_clk);
  endtask
  task automatic rs(input logic [7:0] e);
    go(fslo_pkg::OP_RD_STAT);
    chk("status", {8'h0, e}, {8'h0, rsp_status});
  endtask
  task automatic t_nest();
    go(fslo_pkg::OP_ERS_SUSP);
    chb("esusp", 1'b1, erase_suspended);
    rs(8'hc0);
    go(fslo_pkg::OP_ERS_SUSP, .r(1'b1));
    go(fslo_pkg::OP_PRG, 24'h020000, 16'h1234);
    rs(8'h40);
    go(fslo_pkg::OP_PRG_SUSP);
    chb("psusp", 1'b1, program_suspended);
    go(fslo_pkg::OP_ERS_RES, .r(1'b1));
    go(fslo_pkg::OP_SET_LOCK, .r(1'b1));
    go(fslo_pkg::OP_PRG_RES);
    for (int k = 0; k < 20 && rsp_status !== 8'hc0; k++)
      go(fslo_pkg::OP_RD_STAT);
    chb("prg end", 1'b0, program_running);
    go(fslo_pkg::OP_ERS_RES);
    rs(8'h00);
    $display("test nesting finished");
  endtask
  task automatic t_lock();
    go(fslo_pkg::OP_SET_LOCK, 24'h040000);
    chb("busy lock", 1'b1, done_err);
    go(fslo_pkg::OP_SET_LOCK, 24'h040000);
    chb("lock", 1'b0, done_err);
    program_enable_voltage_low = 1'b1;
    go(fslo_pkg::OP_CLR_LOCK);
    chk("clr tries", 16'h2, 16'(fslo_flash_model_inst.clrs));
    chb("unknown", 1'b1, lock_bits_unknown);
    program_enable_voltage_low = 1'b0;
    go(fslo_pkg::OP_CLR_LOCK);
    chb("clr ok", 1'b0, done_err);
    $display("test locks finished");
  endtask
  task automatic t_otp();
    go(fslo_pkg::OP_OTP_RD);
    chk("lock word", 16'hfffe, rsp_data);
    go(fslo_pkg::OP_OTP_PRG, 24'h5, 16'h00a5);
    go(fslo_pkg::OP_OTP_RD, 24'h5);
    chk("user word", 16'h00a5, rsp_data);
    go(fslo_pkg::OP_OTP_PRG, 24'h1, 16'h0, 1'b1);
    go(fslo_pkg::OP_OTP_LOCK);
    go(fslo_pkg::OP_OTP_RD);
    chk("locked", 16'hfffc, rsp_data);
    byte_mode = 1'b1;
    go(fslo_pkg::OP_OTP_RD);
    chk("lock byte", 16'h00fc, rsp_data);
    byte_mode = 1'b0;
    go(fslo_pkg::OP_OTP_PRG, 24'h6);
    chb("lock err", 1'b1, done_err);
    go(fslo_pkg::OP_CLR_STAT);
    rs(8'h80);
    $display("test otp finished");
  endtask
  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    t_nest();
    t_lock();
    t_otp();
    final_report();
  end
endmodule
